//--- rrs_pkg.sv
// constants and types for the run/stop speed ramp
package rrs_pkg;
    localparam int unsigned   CLK_HZ         = 200_000_000;
    // slew step base: one lsb of output per (time setting) base ticks
    localparam int unsigned   BASE_TICK_NS   = 10_000;
    localparam int unsigned   BASE_TICK_CYC  = BASE_TICK_NS / (1_000_000_000 / CLK_HZ);
    localparam logic [10:0]   BASE_TICK_LAST = 11'(BASE_TICK_CYC - 1);

    // parameter tags
    localparam logic [7:0]    ADDR_LINE_SPEED = 8'h00_aa;
    localparam logic [7:0]    ADDR_RAMP_SKIP  = 8'h00_ab;
    localparam logic [7:0]    ADDR_RISE_TIME  = 8'h00_ac;
    localparam logic [7:0]    ADDR_FALL_TIME  = 8'h00_ad;
    localparam logic [7:0]    ADDR_SLEW_TGT   = 8'h00_ae;
    localparam logic [7:0]    ADDR_SLEW_RES   = 8'h00_af;
    localparam logic [7:0]    ADDR_RAMP_BAND  = 8'h00_b0;
    localparam logic [7:0]    ADDR_RAMP_ACT   = 8'h00_b1;
    localparam logic [7:0]    ADDR_RUN_CMD    = 8'h00_b2;
    localparam logic [7:0]    ADDR_STOP_THR   = 8'h00_b3;
    localparam logic [7:0]    ADDR_RUNNING    = 8'h00_b4;
    localparam logic [7:0]    ADDR_SEQ_STATE  = 8'h00_b5;

    // reset values: percent in 0.01 % units, time in 0.1 s units
    localparam logic [15:0]   RST_LINE_SPEED  = 16'h0000;
    localparam logic [15:0]   RST_RAMP_SKIP   = 16'h0000;
    localparam logic [15:0]   RST_RISE_TIME   = 16'h0064;
    localparam logic [15:0]   RST_FALL_TIME   = 16'h0064;
    localparam logic [15:0]   RST_RUN_CMD     = 16'h0000;
    localparam logic [15:0]   RST_STOP_THR    = 16'h00c8;
    localparam logic [15:0]   RST_RAMP_BAND   = 16'h01f4;

    localparam logic [15:0]   CODE_STOP       = 16'h0000;
    localparam logic [15:0]   CODE_RUN        = 16'h0001;
    localparam logic [15:0]   CODE_RAMP_STOP  = 16'h0002;

    typedef enum logic [1:0] {
        SEQ_STOP,
        SEQ_RUN,
        SEQ_RAMP_STOP
    } rrs_seq_t;
endpackage : rrs_pkg

//--- rrs_slew.sv
// slew limiter: moves the result toward the target one lsb per step
module rrs_slew (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic [15:0] i_target,
    input  wire logic [15:0] i_rise_time,
    input  wire logic [15:0] i_fall_time,
    input  wire logic        i_skip,
    output logic      [15:0] o_result
);
    typedef struct packed {
        logic [10:0] base;
        logic [15:0] sub;
        logic [15:0] res;
    } rrs_slew_st_t;

    rrs_slew_st_t s_q;
    rrs_slew_st_t s_d;

    logic        rising;
    logic [15:0] step_time;

    always_comb begin
        s_d       = s_q;
        rising    = i_target > s_q.res;
        step_time = rising ? i_rise_time : i_fall_time;
        // fixed update tick of 10 us
        if (s_q.base == rrs_pkg::BASE_TICK_LAST) begin
            s_d.base = '0;
        end else begin
            s_d.base = s_q.base + 11'h001;
        end
        if (i_skip) begin
            s_d.res = i_target;
            s_d.sub = '0;
        end else if (i_target == s_q.res) begin
            s_d.sub = '0;
        end else if (step_time == 16'h0000) begin
            s_d.res = i_target;
        end else if (s_q.base == rrs_pkg::BASE_TICK_LAST) begin
            // full scale 10000 lsb over time*0.1 s: one lsb per time base ticks
            if (s_q.sub + 16'h0001 >= step_time) begin
                s_d.sub = '0;
                s_d.res = rising ? s_q.res + 16'h0001 : s_q.res - 16'h0001;
            end else begin
                s_d.sub = s_q.sub + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_result = s_q.res;
endmodule : rrs_slew

//--- rrs_top.sv
// run/stop sequencer with speed ramp and parameter port
// Notes on behaviour
// - writing run one enters Run mode
// - run zero forces ramp input to zero
// - ramping-to-stop ends below zero-speed threshold
// - running flag one unless in Stop
// - state code: stop 0, run 1, ramp-stop 2
// - bypass one passes input straight through
// - ramp output slews toward ramp input
// - full rise takes the rise time
// - full fall takes the fall time
// - ramp input is line speed only in Run
// - ramping flag when input-output gap exceeds band
module rrs_top (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    output logic      [15:0] o_ramp_result,
    output logic             o_running,
    output logic      [1:0]  o_state_code,
    output logic             o_ramping
);
    typedef struct packed {
        rrs_pkg::rrs_seq_t seq;
        logic [15:0]       line_speed;
        logic [15:0]       ramp_skip;
        logic [15:0]       rise_time;
        logic [15:0]       fall_time;
        logic [15:0]       run_cmd;
        logic [15:0]       stop_thr;
        logic [15:0]       ramp_band;
        logic              ramping;
        logic [15:0]       rdata;
    } rrs_top_st_t;

    rrs_top_st_t s_q;
    rrs_top_st_t s_d;

    logic [15:0] target;
    logic [15:0] result;
    logic [15:0] gap;
    logic [15:0] code_full;

    function automatic logic [15:0] state_code(input rrs_pkg::rrs_seq_t st);
        unique case (st)
            rrs_pkg::SEQ_STOP:      state_code = rrs_pkg::CODE_STOP;
            rrs_pkg::SEQ_RUN:       state_code = rrs_pkg::CODE_RUN;
            rrs_pkg::SEQ_RAMP_STOP: state_code = rrs_pkg::CODE_RAMP_STOP;
            default:                state_code = rrs_pkg::CODE_STOP;
        endcase
    endfunction : state_code

    // zero outside Run
    assign target = (s_q.seq == rrs_pkg::SEQ_RUN) ? s_q.line_speed : 16'h0000;
    assign gap    = (target > result) ? target - result : result - target;

    rrs_slew u_slew (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_target    (target),
        .i_rise_time (s_q.rise_time),
        .i_fall_time (s_q.fall_time),
        .i_skip      (s_q.ramp_skip[0]),
        .o_result    (result)
    );

    always_comb begin
        s_d = s_q;
        if (i_wr) begin
            unique case (i_addr)
                rrs_pkg::ADDR_LINE_SPEED: s_d.line_speed = i_wdata;
                rrs_pkg::ADDR_RAMP_SKIP:  s_d.ramp_skip  = i_wdata;
                rrs_pkg::ADDR_RISE_TIME:  s_d.rise_time  = i_wdata;
                rrs_pkg::ADDR_FALL_TIME:  s_d.fall_time  = i_wdata;
                rrs_pkg::ADDR_RUN_CMD:    s_d.run_cmd    = i_wdata;
                rrs_pkg::ADDR_STOP_THR:   s_d.stop_thr   = i_wdata;
                rrs_pkg::ADDR_RAMP_BAND:  s_d.ramp_band  = i_wdata;
                default: ;
            endcase
        end
        // sequencer acts on the stored command
        unique case (s_q.seq)
            rrs_pkg::SEQ_STOP: begin
                if (s_q.run_cmd == 16'h0001) begin
                    s_d.seq = rrs_pkg::SEQ_RUN;
                end
            end
            rrs_pkg::SEQ_RUN: begin
                if (s_q.run_cmd == 16'h0000) begin
                    s_d.seq = rrs_pkg::SEQ_RAMP_STOP;
                end
            end
            rrs_pkg::SEQ_RAMP_STOP: begin
                if (s_q.run_cmd == 16'h0001) begin
                    s_d.seq = rrs_pkg::SEQ_RUN;
                end else if (result < s_q.stop_thr) begin
                    s_d.seq = rrs_pkg::SEQ_STOP;
                end
            end
        endcase
        s_d.ramping = gap > s_q.ramp_band;
        unique case (i_addr)
            rrs_pkg::ADDR_LINE_SPEED: s_d.rdata = s_q.line_speed;
            rrs_pkg::ADDR_RAMP_SKIP:  s_d.rdata = s_q.ramp_skip;
            rrs_pkg::ADDR_RISE_TIME:  s_d.rdata = s_q.rise_time;
            rrs_pkg::ADDR_FALL_TIME:  s_d.rdata = s_q.fall_time;
            rrs_pkg::ADDR_SLEW_TGT:   s_d.rdata = target;
            rrs_pkg::ADDR_SLEW_RES:   s_d.rdata = result;
            rrs_pkg::ADDR_RAMP_BAND:  s_d.rdata = s_q.ramp_band;
            rrs_pkg::ADDR_RAMP_ACT:   s_d.rdata = {15'h0000, s_q.ramping};
            rrs_pkg::ADDR_RUN_CMD:    s_d.rdata = s_q.run_cmd;
            rrs_pkg::ADDR_STOP_THR:   s_d.rdata = s_q.stop_thr;
            rrs_pkg::ADDR_RUNNING:    s_d.rdata = {15'h0000, s_q.seq != rrs_pkg::SEQ_STOP};
            rrs_pkg::ADDR_SEQ_STATE:  s_d.rdata = state_code(s_q.seq);
            default:                  s_d.rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q.seq        <= rrs_pkg::SEQ_STOP;
            s_q.line_speed <= rrs_pkg::RST_LINE_SPEED;
            s_q.ramp_skip  <= rrs_pkg::RST_RAMP_SKIP;
            s_q.rise_time  <= rrs_pkg::RST_RISE_TIME;
            s_q.fall_time  <= rrs_pkg::RST_FALL_TIME;
            s_q.run_cmd    <= rrs_pkg::RST_RUN_CMD;
            s_q.stop_thr   <= rrs_pkg::RST_STOP_THR;
            s_q.ramp_band  <= rrs_pkg::RST_RAMP_BAND;
            s_q.ramping    <= 1'b0;
            s_q.rdata      <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata       = s_q.rdata;
    assign o_ramp_result = result;
    assign o_running     = s_q.seq != rrs_pkg::SEQ_STOP;
    assign code_full     = state_code(s_q.seq);
    assign o_state_code  = code_full[1:0];
    assign o_ramping     = s_q.ramping;

    sequence run_cleared_s;
        s_q.seq == rrs_pkg::SEQ_RUN && s_q.run_cmd == 16'h0000;
    endsequence

    sequence below_zero_s;
        s_q.seq == rrs_pkg::SEQ_RAMP_STOP && s_q.run_cmd == 16'h0000 && result < s_q.stop_thr;
    endsequence

    sequence rise_pending_s;
        !s_q.ramp_skip[0] && target > result;
    endsequence

    sequence fall_pending_s;
        !s_q.ramp_skip[0] && target < result;
    endsequence

    sequence settled_s;
        !s_q.ramp_skip[0] && target == result;
    endsequence

    a_run_entry: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_wr && i_addr == rrs_pkg::ADDR_RUN_CMD && i_wdata == 16'h0001
        |-> ##2 o_state_code == 2'd1)
        else $error("run write did not enter run mode");

    a_stop_begin: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        run_cleared_s |=> o_state_code == 2'd2 && target == 16'h0000)
        else $error("stop sequence did not start");

    a_stop_done: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        below_zero_s |=> o_state_code == 2'd0 && !o_running)
        else $error("ramp stop did not end in stop");

    a_running_read: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_addr == rrs_pkg::ADDR_RUNNING |=> o_rdata == {15'h0000, $past(o_state_code) != 2'd0})
        else $error("running flag read wrong");

    a_code_read: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_addr == rrs_pkg::ADDR_SEQ_STATE |=> o_rdata == {14'h0000, $past(o_state_code)})
        else $error("state code read wrong");

    a_skip_follow: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        s_q.ramp_skip[0] |=> result == $past(target))
        else $error("bypass did not pass input");

    a_slew_step: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !s_q.ramp_skip[0] && s_q.rise_time != 16'h0000 && s_q.fall_time != 16'h0000
        && $stable(s_q.ramp_skip)
        |=> result == $past(result) || result == $past(result) + 16'h0001
            || result == $past(result) - 16'h0001)
        else $error("ramp step larger than one lsb");

    a_rise_toward: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        rise_pending_s |=> result >= $past(result) && result <= $past(target))
        else $error("rising ramp moved the wrong way");

    a_fall_toward: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        fall_pending_s |=> result <= $past(result) && result >= $past(target))
        else $error("falling ramp moved the wrong way");

    a_slew_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        settled_s |=> result == $past(result))
        else $error("ramp output moved while settled");

    a_target_sel: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_state_code != 2'd1 |-> target == 16'h0000)
        else $error("ramp input not zero outside run");

    a_target_run: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_state_code == 2'h1 |-> target == s_q.line_speed)
        else $error("ramp input not line speed in run");

    a_stop_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_state_code == 2'h0 && s_q.run_cmd != 16'h0001 |=> o_state_code == 2'h0)
        else $error("stop left without run command");

    a_reset_clear: assert property (@(posedge i_sys_clk)
        !i_nrst ##1 !i_nrst |-> o_ramp_result == 16'h0000 && o_state_code == 2'h0 && !o_running)
        else $error("reset did not clear ramp and state");

    a_band_flag: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        gap > s_q.ramp_band && $stable(s_q.ramp_band) |=> o_ramping)
        else $error("ramping flag missing");

    a_band_clear: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        gap <= s_q.ramp_band |=> !o_ramping)
        else $error("ramping flag stuck");
endmodule : rrs_top

//--- rrs_line_src.sv
// line speed source model: scales a raw sensor count into 0.01 % units
module rrs_line_src (
    input  wire logic [15:0] i_raw,
    output logic      [15:0] o_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    // zero count is a stopped line, full count is maximum speed
    assign o_speed = 16'((32'(i_raw) * 32'd10000) / 32'd65535);
endmodule : rrs_line_src

//--- tb.sv
// self-checking bench for the run/stop speed ramp
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk    = 1'b0;
    logic        nrst       = 1'b0;
    logic        wr         = 1'b0;
    logic [7:0]  addr       = 8'h00_00;
    logic [15:0] wdata      = 16'h0000;
    logic [15:0] raw        = 16'h0000;
    logic [15:0] speed;
    logic [15:0] rdata;
    logic [15:0] result;
    logic        running;
    logic        ramping;
    logic [1:0]  state_code;
    logic [15:0] tgt;
    int          n_errors   = 0;
    int          num_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    rrs_line_src i_rrs_line_src (.i_raw(raw), .o_speed(speed));
    rrs_top i_rrs_top (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_wr(wr), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .o_ramp_result(result), .o_running(running),
        .o_state_code(state_code), .o_ramping(ramping));

    function automatic logic [15:0] exp_speed(input logic [15:0] r);
        return 16'((32'(r) * 32'd10000) / 32'd65535);
    endfunction : exp_speed

    function automatic logic exp_running(input logic [15:0] code);
        return code != 16'h0000;
    endfunction : exp_running

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", what, e, s);
            n_errors++;
        end
    endtask : chk16

    task automatic chk1(input string what, input logic e, input logic s);
        num_checks++;
        if (s !== e) begin
            $display("wrong value %s expected %b seen %b", what, e, s);
            n_errors++;
        end
    endtask : chk1

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask : wr_reg

    task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
        addr = a;
        cyc(2);
        chk16("rdata", e, rdata);
    endtask : chk_reg

    task automatic chk_state(input logic [15:0] code);
        chk16("state", code, {14'h0000, state_code});
        chk1("running", exp_running(code), running);
    endtask : chk_state

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'h8649));
        cyc(4);
        nrst = 1'b1;
        chk_reg(rrs_pkg::ADDR_RISE_TIME, rrs_pkg::RST_RISE_TIME);
        chk_reg(rrs_pkg::ADDR_FALL_TIME, rrs_pkg::RST_FALL_TIME);
        chk_reg(rrs_pkg::ADDR_STOP_THR, rrs_pkg::RST_STOP_THR);
        chk_reg(rrs_pkg::ADDR_RAMP_BAND, rrs_pkg::RST_RAMP_BAND);
        chk_reg(rrs_pkg::ADDR_RAMP_SKIP, rrs_pkg::RST_RAMP_SKIP);
        chk_reg(rrs_pkg::ADDR_SLEW_RES, 16'h0000);
        wr_reg(rrs_pkg::ADDR_SEQ_STATE, 16'h0002);
        chk_state(rrs_pkg::CODE_STOP);
        // bypass: output follows line speed at once
        raw = 16'($urandom_range(1900, 600));
        tgt = exp_speed(raw);
        wr_reg(rrs_pkg::ADDR_RAMP_SKIP, 16'h0001);
        wr_reg(rrs_pkg::ADDR_LINE_SPEED, speed);
        wr_reg(rrs_pkg::ADDR_RUN_CMD, 16'h0001);
        cyc(1);
        chk_state(rrs_pkg::CODE_RUN);
        chk_reg(rrs_pkg::ADDR_SLEW_TGT, tgt);
        chk_reg(rrs_pkg::ADDR_RUNNING, 16'h0001);
        chk_reg(rrs_pkg::ADDR_SEQ_STATE, rrs_pkg::CODE_RUN);
        chk16("result", tgt, result);
        wr_reg(rrs_pkg::ADDR_RUN_CMD, 16'h0005);
        chk_reg(rrs_pkg::ADDR_RUN_CMD, 16'h0005);
        cyc(2);
        chk_state(rrs_pkg::CODE_RUN);
        // ramped rise, one lsb per base tick
        wr_reg(rrs_pkg::ADDR_RAMP_SKIP, 16'h0000);
        wr_reg(rrs_pkg::ADDR_RISE_TIME, 16'h0001);
        wr_reg(rrs_pkg::ADDR_RAMP_BAND, 16'h0001);
        wr_reg(rrs_pkg::ADDR_LINE_SPEED, tgt + 16'd3);
        cyc(1000);
        chk1("ramping", 1'b1, ramping);
        chk_reg(rrs_pkg::ADDR_RAMP_ACT, 16'h0001);
        chk1("partial", 1'b1, result <= tgt + 16'd1);
        cyc(6500);
        chk16("result", tgt + 16'd3, result);
        chk1("ramping", 1'b0, ramping);
        chk_reg(rrs_pkg::ADDR_RAMP_ACT, 16'h0000);
        // slower rise setting halves the rate
        wr_reg(rrs_pkg::ADDR_RISE_TIME, 16'h0002);
        wr_reg(rrs_pkg::ADDR_LINE_SPEED, tgt + 16'd5);
        cyc(3500);
        chk1("slow rise", 1'b1, result <= tgt + 16'd4);
        cyc(6000);
        chk16("result", tgt + 16'd5, result);
        // stop sequence ends just below the threshold
        wr_reg(rrs_pkg::ADDR_FALL_TIME, 16'h0001);
        wr_reg(rrs_pkg::ADDR_STOP_THR, tgt + 16'd4);
        wr_reg(rrs_pkg::ADDR_RUN_CMD, 16'h0000);
        cyc(1);
        chk_state(rrs_pkg::CODE_RAMP_STOP);
        chk_reg(rrs_pkg::ADDR_SLEW_TGT, 16'h0000);
        chk_reg(rrs_pkg::ADDR_RUNNING, 16'h0001);
        chk_reg(rrs_pkg::ADDR_SEQ_STATE, rrs_pkg::CODE_RAMP_STOP);
        cyc(1000);
        chk_state(rrs_pkg::CODE_RAMP_STOP);
        chk1("falling", 1'b1, result >= tgt + 16'd4);
        cyc(4000);
        chk_state(rrs_pkg::CODE_STOP);
        chk_reg(rrs_pkg::ADDR_RUNNING, 16'h0000);
        chk_reg(8'h00_c0, 16'h0000);
        // second reset while the output is still off zero
        nrst = 1'b0;
        cyc(3);
        chk16("result", 16'h0000, result);
        chk_state(rrs_pkg::CODE_STOP);
        nrst = 1'b1;
        chk_reg(rrs_pkg::ADDR_SLEW_RES, 16'h0000);
        chk_reg(rrs_pkg::ADDR_RISE_TIME, rrs_pkg::RST_RISE_TIME);
        conclude();
    end
endmodule : tb
